// ---- hw/mae_map.vh ----
// Register offsets, field positions and reset values of the alert block
`ifndef MAE_MAP_VH
`define MAE_MAP_VH

// Register offsets on the register port
`define MAE_OFS_MASK_ENABLE   8'h06
`define MAE_OFS_LIMIT_VALUE   8'h07

// Mask/enable field positions
`define MAE_BIT_OVER_CUR      15
`define MAE_BIT_UNDER_CUR     14
`define MAE_BIT_BUS_OVER      13
`define MAE_BIT_BUS_UNDER     12
`define MAE_BIT_POWER_OVER    11
`define MAE_BIT_CONV_READY_EN 10
`define MAE_BIT_ALERT_FLAG    4
`define MAE_BIT_CONV_FLAG     3
`define MAE_BIT_OVF_FLAG      2
`define MAE_BIT_POLARITY      1
`define MAE_BIT_LATCH         0

// Writable bits of mask/enable: 15..10 and 1..0
`define MAE_MASK_WR_BITS      16'hFC03

// Reset values
`define MAE_RST_MASK_ENABLE   16'h0000
`define MAE_RST_LIMIT_VALUE   16'h0000

// Low two mode bits at zero select power-down
`define MAE_MODE_PD_BITS      2'h0

`endif

// ---- hw/mae_limit_cmp.v ----
// Limit comparator: one result word against the limit word
`timescale 1ns/1ps
`default_nettype none

module mae_limit_cmp #(
  parameter WIDTH     = 16,
  parameter IS_SIGNED = 0
) (
  // Operands
  input  wire [WIDTH-1:0] result,
  input  wire [WIDTH-1:0] limit,
  // Outcome
  output wire             above,
  output wire             below
);

  // Signed compare by flipping the sign bit of both operands
  wire [WIDTH-1:0] res_k;
  wire [WIDTH-1:0] lim_k;

  assign res_k = (IS_SIGNED != 0) ? {~result[WIDTH-1], result[WIDTH-2:0]} : result;
  assign lim_k = (IS_SIGNED != 0) ? {~limit[WIDTH-1], limit[WIDTH-2:0]} : limit;
  assign above = (res_k > lim_k);
  assign below = (res_k < lim_k);

endmodule // mae_limit_cmp

`default_nettype wire

// ---- hw/mae_alert_pin.v ----
// Open-collector alert pin driver with selectable polarity
`timescale 1ns/1ps
`default_nettype none

module mae_alert_pin (
  // Clock and reset
  input  wire mclk,
  input  wire arst_n,
  // Control
  input  wire alert_active,
  input  wire alert_polarity,
  // Pin
  output wire alert_pin_o,
  output wire alert_pin_oe_n
);

  reg pull_low_q;

  // Active-low pulls while active; active-high pulls while idle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pull_low_q <= 1'b0;
    end else begin
      pull_low_q <= alert_polarity ? ~alert_active : alert_active;
    end
  end

  // Collector only ever sinks; the pull-up makes the high level
  assign alert_pin_o    = 1'b0;
  assign alert_pin_oe_n = ~pull_low_q;

endmodule // mae_alert_pin

`default_nettype wire

// ---- hw/mae_alert_top.v ----
// Alert generation logic of a current, voltage and power monitor
// What this block does
// - Only the highest enabled limit function among bits 15..11 is compared.
// - Over-current enable alerts when current result exceeds the limit.
// - Under-current enable alerts when current result is below the limit.
// - Bus over-voltage enable alerts when bus result exceeds the limit.
// - Bus under-voltage enable alerts when bus result is below the limit.
// - Power over-limit enable alerts when power result exceeds the limit.
// - Conversion-ready alert enable drives alert when ready flag sets.
// - Ready notice may share the pin; alert flag shows the limit cause.
// - Latch mode keeps alert flag set until mask/enable register read.
// - Transparent mode clears alert flag after next non-alerting conversion.
// - Ready flag sets only when the whole conversion cycle is complete.
// - Configuration writes clear ready flag unless they select power-down.
// - Reading mask/enable register clears the ready flag.
// - Overflow flag sets when the power arithmetic overflows.
// - Alert pin is open-collector; polarity bit one means active-high.
// - Latch bit one selects latch mode; zero gives transparent behaviour.
// - Transparent mode returns pin and flag idle once fault is gone.
// - Latch mode holds pin and flag active until mask/enable read.
// - Mask/enable bits nine to five read back as zero.
// - Current results and limits compare as signed two's complement.
// - Bus-voltage results compare as unsigned values.
// - Power results compare as unsigned, never negative.
`timescale 1ns/1ps
`default_nettype none

`include "mae_map.vh"

module mae_alert_top #(
  parameter DW = 16,
  parameter AW = 8
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          arst_n,
  // Register port from the serial bus engine
  input  wire [AW-1:0] reg_addr,
  input  wire          reg_wr,
  input  wire          reg_rd,
  input  wire [DW-1:0] reg_wdata,
  output wire [DW-1:0] reg_rdata,
  // Configuration write notice
  input  wire          cfg_wr,
  input  wire [2:0]    cfg_wr_mode,
  // Finished measurement results
  input  wire          cur_valid,
  input  wire [DW-1:0] cur_result,
  input  wire          bus_valid,
  input  wire [DW-1:0] bus_result,
  input  wire          pwr_valid,
  input  wire [DW-1:0] pwr_result,
  input  wire          pwr_overflow,
  input  wire          cycle_done,
  // Alert pin and status
  output wire          alert_pin_o,
  output wire          alert_pin_oe_n,
  output wire          alert_active
);

  // Register state
  reg [5:0]    func_en_q;
  reg [5:0]    func_en_d;
  reg          polarity_q;
  reg          polarity_d;
  reg          latch_q;
  reg          latch_d;
  reg [DW-1:0] limit_q;
  reg [DW-1:0] limit_d;
  reg          aff_q;
  reg          aff_d;
  reg          conv_ready_flag_q;
  reg          conv_ready_flag_d;
  reg          ovf_q;
  reg          ovf_d;
  reg [DW-1:0] rdata_q;
  reg [DW-1:0] rdata_d;

  // Access decode
  wire sel_mask;
  wire sel_limit;
  wire mask_rd;
  wire mask_wr;
  wire limit_wr;

  assign sel_mask  = (reg_addr == `MAE_OFS_MASK_ENABLE);
  assign sel_limit = (reg_addr == `MAE_OFS_LIMIT_VALUE);
  assign mask_rd   = reg_rd & sel_mask;
  assign mask_wr   = reg_wr & sel_mask;
  assign limit_wr  = reg_wr & sel_limit;

  // Function enables: index 5 is over-current down to 0 for ready notice
  wire en_over_cur;
  wire en_under_cur;
  wire en_bus_over;
  wire en_bus_under;
  wire en_power_over;
  wire en_conv_ready;

  assign en_over_cur   = func_en_q[5];
  assign en_under_cur  = func_en_q[4];
  assign en_bus_over   = func_en_q[3];
  assign en_bus_under  = func_en_q[2];
  assign en_power_over = func_en_q[1];
  assign en_conv_ready = func_en_q[0];

  // Priority select of the one monitored limit function
  reg sel_over_cur;
  reg sel_under_cur;
  reg sel_bus_over;
  reg sel_bus_under;
  reg sel_power_over;

  always @* begin
    sel_over_cur   = 1'b0;
    sel_under_cur  = 1'b0;
    sel_bus_over   = 1'b0;
    sel_bus_under  = 1'b0;
    sel_power_over = 1'b0;
    if (en_over_cur) begin
      sel_over_cur = 1'b1;
    end else if (en_under_cur) begin
      sel_under_cur = 1'b1;
    end else if (en_bus_over) begin
      sel_bus_over = 1'b1;
    end else if (en_bus_under) begin
      sel_bus_under = 1'b1;
    end else if (en_power_over) begin
      sel_power_over = 1'b1;
    end
  end

  // Comparators; limit word is taken as-is in the compared format
  wire cur_above;
  wire cur_below;
  wire bus_above;
  wire bus_below;
  wire pwr_above;

  mae_limit_cmp #(
    .WIDTH     (DW),
    .IS_SIGNED (1)
  ) u_cmp_cur (
    .result (cur_result),
    .limit  (limit_q),
    .above  (cur_above),
    .below  (cur_below)
  );

  mae_limit_cmp #(
    .WIDTH     (DW),
    .IS_SIGNED (0)
  ) u_cmp_bus (
    .result (bus_result),
    .limit  (limit_q),
    .above  (bus_above),
    .below  (bus_below)
  );

  mae_limit_cmp #(
    .WIDTH     (DW),
    .IS_SIGNED (0)
  ) u_cmp_pwr (
    .result (pwr_result),
    .limit  (limit_q),
    .above  (pwr_above),
    .below  ()
  );

  // A conversion of the monitored kind finished, and whether it faults.
  // Results arrive as the final averaged words, so raw samples never alert.
  reg eval_now;
  reg fault_now;

  always @* begin
    eval_now  = 1'b0;
    fault_now = 1'b0;
    if (sel_over_cur) begin
      eval_now  = cur_valid;
      fault_now = cur_above;
    end else if (sel_under_cur) begin
      eval_now  = cur_valid;
      fault_now = cur_below;
    end else if (sel_bus_over) begin
      eval_now  = bus_valid;
      fault_now = bus_above;
    end else if (sel_bus_under) begin
      eval_now  = bus_valid;
      fault_now = bus_below;
    end else if (sel_power_over) begin
      eval_now  = pwr_valid;
      fault_now = pwr_above;
    end
  end

  // Power-down writes leave the ready flag alone
  wire cfg_clears_ready;

  assign cfg_clears_ready = cfg_wr & (cfg_wr_mode[1:0] != `MAE_MODE_PD_BITS);

  // Register writes
  always @* begin
    func_en_d  = func_en_q;
    polarity_d = polarity_q;
    latch_d    = latch_q;
    limit_d    = limit_q;
    if (mask_wr) begin
      func_en_d  = reg_wdata[`MAE_BIT_OVER_CUR:`MAE_BIT_CONV_READY_EN];
      polarity_d = reg_wdata[`MAE_BIT_POLARITY];
      latch_d    = reg_wdata[`MAE_BIT_LATCH];
    end
    if (limit_wr) begin
      limit_d = reg_wdata;
    end
  end

  // Flags; in every case a setting event wins over a clear in the same cycle
  always @* begin
    aff_d = aff_q;
    if (latch_q) begin
      if (mask_rd) begin
        aff_d = 1'b0;
      end
    end else if (eval_now && !fault_now) begin
      aff_d = 1'b0;
    end
    if (eval_now && fault_now) begin
      aff_d = 1'b1;
    end
  end

  always @* begin
    conv_ready_flag_d = conv_ready_flag_q;
    if (mask_rd || cfg_clears_ready) begin
      conv_ready_flag_d = 1'b0;
    end
    if (cycle_done) begin
      conv_ready_flag_d = 1'b1;
    end
  end

  // Overflow follows each power product; it is a status, not an event
  always @* begin
    ovf_d = ovf_q;
    if (pwr_valid) begin
      ovf_d = pwr_overflow;
    end
  end

  // Read data, sampled before the read side effects take hold
  wire [DW-1:0] mask_view;

  assign mask_view = {func_en_q, 5'h00, aff_q, conv_ready_flag_q, ovf_q, polarity_q, latch_q};

  always @* begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (sel_mask) begin
        rdata_d = mask_view;
      end else if (sel_limit) begin
        rdata_d = limit_q;
      end else begin
        rdata_d = {DW{1'b0}};
      end
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      func_en_q  <= 6'h00;
      polarity_q <= 1'b0;
      latch_q    <= 1'b0;
      limit_q    <= `MAE_RST_LIMIT_VALUE;
      aff_q      <= 1'b0;
      conv_ready_flag_q     <= 1'b0;
      ovf_q      <= 1'b0;
      rdata_q    <= {DW{1'b0}};
    end else begin
      func_en_q  <= func_en_d;
      polarity_q <= polarity_d;
      latch_q    <= latch_d;
      limit_q    <= limit_d;
      aff_q      <= aff_d;
      conv_ready_flag_q     <= conv_ready_flag_d;
      ovf_q      <= ovf_d;
      rdata_q    <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Pin is active for the monitored fault, or for the ready notice if enabled.
  // Ready alert also follows the flag, so a latched ready clears on the read.
  assign alert_active = aff_q | (en_conv_ready & conv_ready_flag_q);

  mae_alert_pin u_pin (
    .mclk           (mclk),
    .arst_n         (arst_n),
    .alert_active   (alert_active),
    .alert_polarity (polarity_q),
    .alert_pin_o    (alert_pin_o),
    .alert_pin_oe_n (alert_pin_oe_n)
  );

endmodule // mae_alert_top

`default_nettype wire

// ---- testbench/mae_alert_sva.sv ----
// Port checker for the alert block
`timescale 1ns/1ps
`default_nettype none
module mae_alert_sva #(parameter DW = 16, parameter AW = 8) (
  // Clock and reset
  input wire logic          mclk,
  input wire logic          arst_n,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic [DW-1:0] reg_rdata,
  // Configuration notice
  input wire logic          cfg_wr,
  input wire logic [2:0]    cfg_wr_mode,
  // Results
  input wire logic          cur_valid,
  input wire logic [DW-1:0] cur_result,
  input wire logic          bus_valid,
  input wire logic [DW-1:0] bus_result,
  input wire logic          pwr_valid,
  input wire logic [DW-1:0] pwr_result,
  input wire logic          pwr_overflow,
  input wire logic          cycle_done,
  // Pin and status
  input wire logic          alert_pin_o,
  input wire logic          alert_pin_oe_n,
  input wire logic          alert_active
);
  logic [DW-1:0] mask_q;
  logic [DW-1:0] lim_q;
  wire ev = cur_valid | bus_valid | pwr_valid | cycle_done;
  wire mwr = reg_wr && reg_addr == 8'h06;
  wire mrd = reg_rd && reg_addr == 8'h06;
  // Shadow copies of what the host wrote
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= 16'h0000;
      lim_q <= 16'h0000;
    end else begin
      if (mwr) mask_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h07) lim_q <= reg_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_bus_over;
    bus_valid && mask_q[15:13] == 3'b001 && bus_result > lim_q;
  endsequence
  AST_PIN_SINK: assert property (alert_pin_o == 1'b0)
    else $error("alert pin drives high");
  AST_PIN_POL: assert property (alert_pin_oe_n == ($past(alert_active) ~^ $past(mask_q[1])))
    else $error("alert pin level wrong");
  AST_EN_RD: assert property (mrd |=> reg_rdata[15:5] == {$past(mask_q[15:10]), 5'h00})
    else $error("mask readback wrong");
  AST_LIM_RD: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata == $past(lim_q))
    else $error("limit readback wrong");
  AST_RISE_CAUSE: assert property ($rose(alert_active) |-> $past(ev) || $past(mwr))
    else $error("alert rose without a result");
  AST_LATCH_HOLD: assert property ($fell(alert_active) && $past(mask_q[0]) |-> $past(mrd || cfg_wr || mwr))
    else $error("latched alert released alone");
  AST_RD_CLR: assert property (mrd && mask_q[0] && !ev && !reg_wr |=> !alert_active)
    else $error("read did not clear");
  AST_CFG_PD: assert property (cfg_wr && cfg_wr_mode[1:0] == 2'h0 && alert_active && !ev && !reg_rd && !reg_wr |=> alert_active)
    else $error("power-down write cleared");
  AST_BUS_OVER: assert property (s_bus_over |=> alert_active)
    else $error("bus over limit missed");
  AST_OC: assert property (cur_valid && mask_q[15] && $signed(cur_result) > $signed(lim_q) |=> alert_active)
    else $error("over-current missed");
endmodule // mae_alert_sva
bind mae_alert_top mae_alert_sva #(.DW(DW), .AW(AW)) u_sva (
  .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_wr(cfg_wr), .cfg_wr_mode(cfg_wr_mode),
  .cur_valid(cur_valid), .cur_result(cur_result), .bus_valid(bus_valid),
  .bus_result(bus_result), .pwr_valid(pwr_valid), .pwr_result(pwr_result),
  .pwr_overflow(pwr_overflow), .cycle_done(cycle_done), .alert_pin_o(alert_pin_o),
  .alert_pin_oe_n(alert_pin_oe_n), .alert_active(alert_active));
`default_nettype wire

// ---- testbench/mae_host_mdl.sv ----
// Host side of the alert line: pull-up and the host's reading of it
`timescale 1ns/1ps
`default_nettype none
module mae_host_mdl (
  // Device pin
  input  wire logic alert_pin_o,
  input  wire logic alert_pin_oe_n,
  // Host view
  input  wire logic alert_polarity,
  output logic      alert_line,
  output logic      alert_seen
);
  // Open collector only sinks, so a released pin rises to the pull-up
  assign alert_line = alert_pin_oe_n ? 1'b1 : alert_pin_o;
  assign alert_seen = alert_line ~^ alert_polarity;
endmodule // mae_host_mdl
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the alert block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk, arst_n, reg_wr, reg_rd, cfg_wr, cur_valid, bus_valid, pwr_valid;
  logic        pwr_overflow, cycle_done, alert_pin_o, alert_pin_oe_n, alert_active;
  logic        alert_line, alert_seen, power_over_alert_en;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cur_result, bus_result, pwr_result;
  logic [2:0]  cfg_wr_mode;
  int          fail_count = 0;
  int          n_checks = 0;
  mae_alert_top dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_wr(cfg_wr),
    .cfg_wr_mode(cfg_wr_mode), .cur_valid(cur_valid), .cur_result(cur_result),
    .bus_valid(bus_valid), .bus_result(bus_result), .pwr_valid(pwr_valid),
    .pwr_result(pwr_result), .pwr_overflow(pwr_overflow), .cycle_done(cycle_done),
    .alert_pin_o(alert_pin_o), .alert_pin_oe_n(alert_pin_oe_n), .alert_active(alert_active));
  mae_host_mdl host (.alert_pin_o(alert_pin_o), .alert_pin_oe_n(alert_pin_oe_n),
    .alert_polarity(power_over_alert_en), .alert_line(alert_line), .alert_seen(alert_seen));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // Inputs move 1 ns after the edge so no race with the sampling edge
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    // One idle edge so a following strobe never rises in the same time step
    tick;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    d = reg_rdata;
    tick;
  endtask
  task automatic cfg(input logic [2:0] m);
    cfg_wr_mode = m;
    cfg_wr = 1'b1;
    tick;
    cfg_wr = 1'b0;
  endtask
  // Kind 0 current, 1 bus, 2 power, 3 end of cycle
  task automatic meas(input int k, input logic [15:0] v);
    cur_result = v;
    bus_result = v;
    pwr_result = v;
    cur_valid = k == 0;
    bus_valid = k == 1;
    pwr_valid = k == 2;
    cycle_done = k == 3;
    tick;
    {cur_valid, bus_valid, pwr_valid, cycle_done} = 4'h0;
  endtask
  task automatic chk_alert(input logic e);
    chk(alert_active === e, "alert status");
    tick;
    chk(alert_seen === e, "alert pin");
  endtask
  task automatic t_regs;
    logic [15:0] d;
    chk(alert_line === 1'b1, "pin after reset");
    rd(8'h06, d);
    chk(d === 16'h0000, "mask reset");
    rd(8'h07, d);
    chk(d === 16'h0000, "limit reset");
    rd(8'h05, d);
    chk(d === 16'h0000, "unmapped read");
    wr(8'h06, 16'hFFFF);
    rd(8'h06, d);
    chk(d === 16'hFC03, "mask readback");
    wr(8'h06, 16'h0000);
  endtask
  task automatic t_each;
    logic [15:0] d;
    logic [15:0] bad [5] = '{16'h0200, 16'hFF00, 16'h0101, 16'h00FF, 16'h8000};
    wr(8'h07, 16'h0100);
    rd(8'h07, d);
    chk(d === 16'h0100, "limit readback");
    for (int i = 0; i < 5; i++) begin
      wr(8'h06, 16'h8000 >> i);
      meas(i / 2, bad[i]);
      chk_alert(1'b1);
      rd(8'h06, d);
      chk(d[4] === 1'b1, "function flag");
      meas(i / 2, 16'h0100);
      chk_alert(1'b0);
    end
  endtask
  task automatic t_prio;
    wr(8'h06, 16'hF800);
    meas(0, 16'hFFF0);
    chk_alert(1'b0);
    meas(1, 16'h0001);
    chk_alert(1'b0);
    meas(0, 16'h0200);
    chk_alert(1'b1);
    meas(0, 16'h0000);
    chk_alert(1'b0);
  endtask
  task automatic t_latch;
    logic [15:0] d;
    wr(8'h06, 16'h2003);
    power_over_alert_en = 1'b1;
    meas(1, 16'h0200);
    chk_alert(1'b1);
    meas(1, 16'h0000);
    chk_alert(1'b1);
    rd(8'h06, d);
    chk(d[4] === 1'b1, "latched flag");
    chk_alert(1'b0);
    wr(8'h06, 16'h0000);
    power_over_alert_en = 1'b0;
  endtask
  task automatic t_conv;
    logic [15:0] d;
    wr(8'h06, 16'h2400);
    meas(0, 16'h0000);
    chk_alert(1'b0);
    meas(3, 16'h0000);
    chk_alert(1'b1);
    rd(8'h06, d);
    chk(d[4:3] === 2'b01, "ready without function");
    chk_alert(1'b0);
    meas(3, 16'h0000);
    cfg(3'b100);
    chk_alert(1'b1);
    cfg(3'b011);
    chk_alert(1'b0);
    meas(1, 16'h0200);
    rd(8'h06, d);
    chk(d[4:3] === 2'b10, "function without ready");
    meas(1, 16'h0000);
    wr(8'h06, 16'h0000);
  endtask
  task automatic t_ovf;
    logic [15:0] d;
    pwr_overflow = 1'b1;
    meas(2, 16'hFFFF);
    pwr_overflow = 1'b0;
    rd(8'h06, d);
    chk(d[2] === 1'b1, "overflow set");
    meas(2, 16'h0001);
    rd(8'h06, d);
    chk(d[2] === 1'b0, "overflow reload");
  endtask
  // The whole sequence needs about 115 cycles; this allows ample margin
  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    arst_n = 1'b0;
    power_over_alert_en = 1'b0;
    {reg_wr, reg_rd, cfg_wr, cur_valid, bus_valid, pwr_valid, pwr_overflow, cycle_done} = 8'h00;
    {reg_addr, reg_wdata, cur_result, bus_result, pwr_result, cfg_wr_mode} = '0;
    repeat (12) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    t_regs;
    t_each;
    t_prio;
    t_latch;
    t_conv;
    t_ovf;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
